/* rpfi_map.vh */
// Register map and constants of the pseudo-fault injector
// Behaviour
// - Feature bit 30 reports restart mode
// - Feature bit 29 zero; fixed fault codes
// - Feature bit 28 zero; inject on access
// - Syndrome written implies syndrome flag set
// - Control bit 12 reads one; flag set
// - Control bit 11 zero; no fault address
// - Control bit 10 zero; poison cleared
// - Control bit 9 zero; reported cleared
// - Control bit 8 zero; never critical
// - Control bit 0 zero; overflow cleared
// - Enable resets zero; write one loads counter
// - Restart clear stops, set reloads
// - Counter reaching zero enters injection state
// - Corrected field 01 records code 10
// - Deferred bit injects deferred error
// - Uncontainable bit injects uncontainable error
// - Latent and recoverable bits read zero
// - Feature bit 2 reports unrecoverable support
// - Unconsumed access still injects here
`ifndef RPFI_MAP_VH
`define RPFI_MAP_VH

`define RPFI_ADDR_W        12
`define RPFI_DATA_W        64
`define RPFI_CNT_W         32
`define RPFI_OFF_FEAT      12'h800
`define RPFI_OFF_CTL       12'h808
`define RPFI_OFF_RELOAD    12'h810
`define RPFI_OFF_STATE     12'h818

`define RPFI_FEAT_VALUE    64'h0000000040000066
`define RPFI_CTL_RST       64'h0000000000001000
`define RPFI_CTL_WMASK     64'h00000000C00000E6
`define RPFI_CTL_RAO       64'h0000000000001000

`define RPFI_BIT_EN        31
`define RPFI_BIT_RESTART   30
`define RPFI_BIT_MV        12
`define RPFI_CE_HI         7
`define RPFI_CE_LO         6
`define RPFI_BIT_DE        5
`define RPFI_BIT_UEU       2
`define RPFI_BIT_UC        1

`define RPFI_CE_NONSPEC    2'h1
`define RPFI_CE_CODE       2'h2
`define RPFI_IMPL_FAULT_CODE_VALUE    8'h01
`define RPFI_ARCHITECTED_FAULT_CODE_VALUE    8'h0E

`endif

/* rpfi_injector.v */
// Pseudo-fault generation logic of one error record
`include "rpfi_map.vh"

module rpfi_injector (
	core_clk,
	sys_rst,
	reg_addr,
	reg_wdata,
	reg_wr,
	reg_rd,
	reg_rdata,
	comp_access,
	comp_data_consumed,
	rec_valid,
	rec_ce,
	rec_de,
	rec_uc,
	rec_ueu,
	rec_mv,
	rec_av,
	rec_pn,
	rec_er,
	rec_ci,
	rec_of,
	rec_impl_fault_code,
	rec_architected_fault_code,
	inject_state
);

	input  wire                      core_clk;
	input  wire                      sys_rst;
	input  wire [`RPFI_ADDR_W-1:0]   reg_addr;
	input  wire [`RPFI_DATA_W-1:0]   reg_wdata;
	input  wire                      reg_wr;
	input  wire                      reg_rd;
	output reg  [`RPFI_DATA_W-1:0]   reg_rdata;
	input  wire                      comp_access;
	input  wire                      comp_data_consumed;
	output reg                       rec_valid;
	output reg  [1:0]                rec_ce;
	output reg                       rec_de;
	output reg                       rec_uc;
	output reg                       rec_ueu;
	output reg                       rec_mv;
	output reg                       rec_av;
	output reg                       rec_pn;
	output reg                       rec_er;
	output reg                       rec_ci;
	output reg                       rec_of;
	output reg  [7:0]                rec_impl_fault_code;
	output reg  [7:0]                rec_architected_fault_code;
	output wire                      inject_state;

	localparam ST_IDLE   = 1'b0;
	localparam ST_INJECT = 1'b1;

	// Register storage
	reg  [`RPFI_DATA_W-1:0]          ctl_r;
	reg  [`RPFI_DATA_W-1:0]          ctl_nxt;
	reg  [`RPFI_CNT_W-1:0]           reload_r;
	reg  [`RPFI_CNT_W-1:0]           reload_nxt;
	reg  [`RPFI_CNT_W-1:0]           cnt_r;
	reg  [`RPFI_CNT_W-1:0]           cnt_nxt;
	reg                              st_r;
	reg                              st_nxt;
	reg  [`RPFI_DATA_W-1:0]          rdata_nxt;
	reg                              rec_valid_nxt;
	reg  [1:0]                       rec_ce_nxt;
	reg                              rec_de_nxt;
	reg                              rec_uc_nxt;
	reg                              rec_ueu_nxt;
	reg                              rec_mv_nxt;
	reg                              rec_av_nxt;
	reg                              rec_pn_nxt;
	reg                              rec_er_nxt;
	reg                              rec_ci_nxt;
	reg                              rec_of_nxt;
	reg  [7:0]                       rec_impl_fault_code_nxt;
	reg  [7:0]                       rec_architected_fault_code_nxt;

	// Decoded controls
	wire                             cnt_en;
	wire                             restart;
	wire                             ce_sel;
	wire                             de_sel;
	wire                             uc_sel;
	wire                             ueu_sel;
	wire                             any_sel;
	wire                             wr_ctl;
	wire                             wr_reload;
	wire                             load_cnt;
	wire                             hit_zero;
	wire                             fire;
	wire                             at_feat;
	wire                             at_ctl;
	wire                             at_reload;
	wire                             at_state;
	wire                             cnt_zero;
	wire                             cnt_one;

	// Address match helper
	function addr_is;
		input [`RPFI_ADDR_W-1:0] a;
		input [`RPFI_ADDR_W-1:0] off;
		begin
			addr_is = (a == off);
		end
	endfunction

	// Sanitise a value written to control
	function [`RPFI_DATA_W-1:0] ctl_fix;
		input [`RPFI_DATA_W-1:0] v;
		begin
			ctl_fix = (v & `RPFI_CTL_WMASK) | `RPFI_CTL_RAO;
		end
	endfunction

	assign cnt_en    = ctl_r[`RPFI_BIT_EN];
	assign restart   = ctl_r[`RPFI_BIT_RESTART];
	assign ce_sel    = (ctl_r[`RPFI_CE_HI:`RPFI_CE_LO] == `RPFI_CE_NONSPEC);
	assign de_sel    = ctl_r[`RPFI_BIT_DE];
	assign uc_sel    = ctl_r[`RPFI_BIT_UC];
	assign ueu_sel   = ctl_r[`RPFI_BIT_UEU];
	assign any_sel   = ce_sel | de_sel | uc_sel | ueu_sel;

	assign wr_ctl    = reg_wr & addr_is(reg_addr, `RPFI_OFF_CTL);
	assign wr_reload = reg_wr & addr_is(reg_addr, `RPFI_OFF_RELOAD);

	// Read address decode
	assign at_feat   = addr_is(reg_addr, `RPFI_OFF_FEAT);
	assign at_ctl    = addr_is(reg_addr, `RPFI_OFF_CTL);
	assign at_reload = addr_is(reg_addr, `RPFI_OFF_RELOAD);
	assign at_state  = addr_is(reg_addr, `RPFI_OFF_STATE);

	// Counter end points
	assign cnt_zero  = (cnt_r == {`RPFI_CNT_W{1'b0}});
	assign cnt_one   = (cnt_r == {{(`RPFI_CNT_W-1){1'b0}}, 1'b1});

	// Writing one to the enable reloads the counter
	assign load_cnt  = wr_ctl & reg_wdata[`RPFI_BIT_EN];

	// Counter steps from one to zero this cycle
	assign hit_zero  = cnt_en & ~load_cnt & cnt_one;

	// Injection fires on any access, consumed or not
	assign fire      = (st_r == ST_INJECT) & comp_access;

	assign inject_state = st_r;

	// Control register next value
	always @* begin
		ctl_nxt = ctl_r;
		if (wr_ctl) begin
			ctl_nxt = ctl_fix(reg_wdata);
		end
	end

	// Reload value register next value
	always @* begin
		reload_nxt = reload_r;
		if (wr_reload) begin
			reload_nxt = reg_wdata[`RPFI_CNT_W-1:0];
		end
	end

	// Generation counter
	always @* begin
		cnt_nxt = cnt_r;
		if (load_cnt) begin
			cnt_nxt = reload_r;
		end else if (cnt_en && !cnt_zero) begin
			cnt_nxt = cnt_r - {{(`RPFI_CNT_W-1){1'b0}}, 1'b1};
			if (hit_zero && restart) begin
				cnt_nxt = reload_r;
			end
		end
	end

	// Injection state; entry wins over leaving
	always @* begin
		st_nxt = st_r;
		case (st_r)
			ST_IDLE: begin
				if (hit_zero) begin
					st_nxt = ST_INJECT;
				end
			end
			ST_INJECT: begin
				if (fire && !hit_zero) begin
					st_nxt = ST_IDLE;
				end
			end
			default: begin
				st_nxt = ST_IDLE;
			end
		endcase
	end

	// Read mux; unmapped reads zero
	always @* begin
		rdata_nxt = {`RPFI_DATA_W{1'b0}};
		if (reg_rd) begin
			if (at_feat) begin
				rdata_nxt = `RPFI_FEAT_VALUE;
			end else if (at_ctl) begin
				rdata_nxt = ctl_r;
			end else if (at_reload) begin
				rdata_nxt = {{(`RPFI_DATA_W-`RPFI_CNT_W){1'b0}}, reload_r};
			end else if (at_state) begin
				rdata_nxt = {{(`RPFI_DATA_W-`RPFI_CNT_W-1){1'b0}}, st_r, cnt_r};
			end
		end
	end

	// Control register
	always @(posedge core_clk) begin
		if (sys_rst) begin
			ctl_r <= `RPFI_CTL_RST;
		end else begin
			ctl_r <= ctl_nxt;
		end
	end

	// Countdown reload register
	always @(posedge core_clk) begin
		if (sys_rst) begin
			reload_r <= {`RPFI_CNT_W{1'b0}};
		end else begin
			reload_r <= reload_nxt;
		end
	end

	// Generation counter flops
	always @(posedge core_clk) begin
		if (sys_rst) begin
			cnt_r <= {`RPFI_CNT_W{1'b0}};
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	// Injection state flop
	always @(posedge core_clk) begin
		if (sys_rst) begin
			st_r <= ST_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Read data, one cycle after the strobe
	always @(posedge core_clk) begin
		if (sys_rst) begin
			reg_rdata <= {`RPFI_DATA_W{1'b0}};
		end else begin
			reg_rdata <= rdata_nxt;
		end
	end

	// Record pulse, one cycle after the triggering access
	always @* begin
		rec_valid_nxt = fire & any_sel;
	end

	// Error types; held until the next record
	always @* begin
		rec_ce_nxt  = rec_ce;
		rec_de_nxt  = rec_de;
		rec_uc_nxt  = rec_uc;
		rec_ueu_nxt = rec_ueu;
		if (fire && any_sel) begin
			rec_ce_nxt  = ce_sel ? `RPFI_CE_CODE : 2'h0;
			rec_de_nxt  = de_sel;
			rec_uc_nxt  = uc_sel;
			rec_ueu_nxt = ueu_sel;
		end
	end

	// Syndrome flags and fault codes
	always @* begin
		rec_mv_nxt   = rec_mv;
		rec_av_nxt   = rec_av;
		rec_pn_nxt   = rec_pn;
		rec_er_nxt   = rec_er;
		rec_ci_nxt   = rec_ci;
		rec_of_nxt   = rec_of;
		rec_impl_fault_code_nxt = rec_impl_fault_code;
		rec_architected_fault_code_nxt = rec_architected_fault_code;
		if (fire && any_sel) begin
			rec_mv_nxt   = ctl_r[`RPFI_BIT_MV];
			rec_av_nxt   = 1'b0;
			rec_pn_nxt   = 1'b0;
			rec_er_nxt   = 1'b0;
			rec_ci_nxt   = 1'b0;
			rec_of_nxt   = 1'b0;
			rec_impl_fault_code_nxt = `RPFI_IMPL_FAULT_CODE_VALUE;
			rec_architected_fault_code_nxt = `RPFI_ARCHITECTED_FAULT_CODE_VALUE;
		end
	end

	// Record pulse flop
	always @(posedge core_clk) begin
		if (sys_rst) begin
			rec_valid <= 1'b0;
		end else begin
			rec_valid <= rec_valid_nxt;
		end
	end

	// Error type flops
	always @(posedge core_clk) begin
		if (sys_rst) begin
			rec_ce  <= 2'h0;
			rec_de  <= 1'b0;
			rec_uc  <= 1'b0;
			rec_ueu <= 1'b0;
		end else begin
			rec_ce  <= rec_ce_nxt;
			rec_de  <= rec_de_nxt;
			rec_uc  <= rec_uc_nxt;
			rec_ueu <= rec_ueu_nxt;
		end
	end

	// Syndrome flag and code flops
	always @(posedge core_clk) begin
		if (sys_rst) begin
			rec_mv   <= 1'b0;
			rec_av   <= 1'b0;
			rec_pn   <= 1'b0;
			rec_er   <= 1'b0;
			rec_ci   <= 1'b0;
			rec_of   <= 1'b0;
			rec_impl_fault_code <= 8'h00;
			rec_architected_fault_code <= 8'h00;
		end else begin
			rec_mv   <= rec_mv_nxt;
			rec_av   <= rec_av_nxt;
			rec_pn   <= rec_pn_nxt;
			rec_er   <= rec_er_nxt;
			rec_ci   <= rec_ci_nxt;
			rec_of   <= rec_of_nxt;
			rec_impl_fault_code <= rec_impl_fault_code_nxt;
			rec_architected_fault_code <= rec_architected_fault_code_nxt;
		end
	end

endmodule // rpfi_injector

/* rpfi_injector_assertions.sv */
// Port checker of the pseudo-fault injector
module rpfi_injector_assertions (
	input logic        core_clk,
	input logic        sys_rst,
	input logic [11:0] reg_addr,
	input logic        reg_rd,
	input logic [63:0] reg_rdata,
	input logic        comp_access,
	input logic        inject_state,
	input logic        rec_valid,
	input logic [1:0]  rec_ce,
	input logic        rec_de,
	input logic        rec_uc,
	input logic        rec_ueu,
	input logic        rec_mv,
	input logic        rec_av,
	input logic        rec_pn,
	input logic        rec_er,
	input logic        rec_ci,
	input logic        rec_of
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	a_mv_set: assert property (rec_valid |-> rec_mv)
		else $error("syndrome flag low");
	a_flags_zero: assert property (rec_valid |-> !(rec_av | rec_pn | rec_er | rec_ci | rec_of))
		else $error("record flag set");
	a_ce_code: assert property (rec_valid |-> rec_ce == 2'h0 || rec_ce == 2'h2)
		else $error("bad corrected code");
	a_rec_type: assert property (rec_valid |-> rec_ce != 2'h0 || rec_de || rec_uc || rec_ueu)
		else $error("record without type");
	a_rec_cause: assert property (rec_valid |-> $past(comp_access && inject_state))
		else $error("record without access");
	a_state_leave: assert property (comp_access && inject_state ##1 rec_valid |-> !inject_state)
		else $error("state kept");
	a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 64'h0)
		else $error("read data outside slot");
	a_feat_read: assert property ($past(reg_rd) && $past(reg_addr) == 12'h800 |-> reg_rdata == 64'h40000066)
		else $error("feature value wrong");
	a_ctl_fixed: assert property ($past(reg_rd) && $past(reg_addr) == 12'h808
		|-> (reg_rdata & 64'hFFFFFFFF3FFFFF19) == 64'h1000)
		else $error("control fixed bits wrong");
endmodule // rpfi_injector_assertions

bind rpfi_injector rpfi_injector_assertions rpfi_injector_assertions_inst (
	.core_clk     (core_clk),
	.sys_rst      (sys_rst),
	.reg_addr     (reg_addr),
	.reg_rd       (reg_rd),
	.reg_rdata    (reg_rdata),
	.comp_access  (comp_access),
	.inject_state (inject_state),
	.rec_valid    (rec_valid),
	.rec_ce       (rec_ce),
	.rec_de       (rec_de),
	.rec_uc       (rec_uc),
	.rec_ueu      (rec_ueu),
	.rec_mv       (rec_mv),
	.rec_av       (rec_av),
	.rec_pn       (rec_pn),
	.rec_er       (rec_er),
	.rec_ci       (rec_ci),
	.rec_of       (rec_of)
);

/* rpfi_injector_test.sv */
// Self-checking bench of the pseudo-fault injector
module rpfi_injector_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk = 0;
	logic        sys_rst = 1;
	logic [11:0] reg_addr = 0;
	logic [63:0] reg_wdata = 0;
	logic        reg_wr = 0;
	logic        reg_rd = 0;
	logic        comp_access = 0;
	logic        comp_data_consumed = 0;
	wire  [63:0] reg_rdata;
	wire  [1:0]  rec_ce;
	wire  [7:0]  rec_impl_fault_code, rec_architected_fault_code;
	wire         rec_valid, rec_de, rec_uc, rec_ueu, rec_mv, rec_av, rec_pn, rec_er, rec_ci, rec_of, inject_state;
	int          num_errors = 0;
	int          num_checks = 0;
	int          n;
	logic [11:0] ra [5] = '{12'h800, 12'h808, 12'h808, 12'h810, 12'h820};
	logic [63:0] rw [5] = '{64'hFFFFFFFFFFFFFFFF, 64'hFFFFFFFFFFFFFFFF, 64'h0, 64'h5, 64'hFF};
	logic [63:0] rx [5] = '{64'h40000066, 64'hC00010E6, 64'h1000, 64'h5, 64'h0};
	logic [63:0] ic [5] = '{64'h40, 64'h20, 64'h2, 64'h4, 64'h80};
	logic [5:0]  ix [5] = '{6'h30, 6'h24, 6'h22, 6'h21, 6'h01};
	rpfi_injector rpfi_injector_inst (
		.core_clk           (core_clk),
		.sys_rst            (sys_rst),
		.reg_addr           (reg_addr),
		.reg_wdata          (reg_wdata),
		.reg_wr             (reg_wr),
		.reg_rd             (reg_rd),
		.reg_rdata          (reg_rdata),
		.comp_access        (comp_access),
		.comp_data_consumed (comp_data_consumed),
		.rec_valid          (rec_valid),
		.rec_ce             (rec_ce),
		.rec_de             (rec_de),
		.rec_uc             (rec_uc),
		.rec_ueu            (rec_ueu),
		.rec_mv             (rec_mv),
		.rec_av             (rec_av),
		.rec_pn             (rec_pn),
		.rec_er             (rec_er),
		.rec_ci             (rec_ci),
		.rec_of             (rec_of),
		.rec_impl_fault_code           (rec_impl_fault_code),
		.rec_architected_fault_code           (rec_architected_fault_code),
		.inject_state       (inject_state)
	);
	initial forever #2 core_clk = ~core_clk;
	task chk(input string s, input logic [63:0] e, input logic [63:0] v);
		num_checks++;
		if (v !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", s, e, v);
		end
	endtask
	task wr(input logic [11:0] a, input logic [63:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge core_clk);
		reg_wr <= 0;
		#1;
	endtask
	task rd(input logic [11:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge core_clk);
		reg_rd <= 0;
		#1;
	endtask
	task hit;
		@(posedge core_clk);
		comp_access <= 1;
		@(posedge core_clk);
		comp_access <= 0;
		#1;
	endtask
	task arm(input logic [63:0] c, input logic [63:0] r);
		wr(12'h810, r);
		wr(12'h808, 64'h80000000 | c);
		n = 0;
		while (inject_state !== 1 && n < 50) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		chk("count", r, 64'(n));
	endtask
	task close_out;
		$display("Checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		#10000;
		num_errors++;
		close_out;
	end
	initial begin
		repeat (10) @(posedge core_clk);
		sys_rst <= 0;
		rd(12'h808);
		chk("ctl reset", 64'h1000, reg_rdata);
		for (int i = 0; i < 5; i++) begin
			wr(ra[i], rw[i]);
			rd(ra[i]);
			chk("reg", rx[i], reg_rdata);
		end
		for (int i = 0; i < 5; i++) begin
			arm(ic[i], 3);
			hit;
			chk("record", ix[i], {rec_valid, rec_ce, rec_de, rec_uc, rec_ueu});
			if (ix[i] != 0) begin
				chk("flags", 22'h20010E, {rec_mv, rec_av, rec_pn, rec_er, rec_ci, rec_of, rec_impl_fault_code, rec_architected_fault_code});
			end
			chk("state", 0, inject_state);
		end
		arm(64'h40000020, 20);
		repeat (4) @(posedge core_clk);
		rd(12'h818);
		chk("restart", 1, reg_rdata[32] && reg_rdata[31:0] != 0);
		hit;
		arm(64'h20, 2);
		repeat (4) @(posedge core_clk);
		rd(12'h818);
		chk("stop", 64'h100000000, reg_rdata);
		@(posedge core_clk);
		sys_rst <= 1;
		repeat (2) @(posedge core_clk);
		sys_rst <= 0;
		#1;
		chk("reset state", 0, inject_state);
		chk("reset record", 0, {rec_valid, rec_ce, rec_mv, rec_impl_fault_code, rec_architected_fault_code});
		rd(12'h818);
		chk("reset counter", 0, reg_rdata);
		rd(12'h808);
		chk("reset ctl", 64'h1000, reg_rdata);
		close_out;
	end
endmodule // rpfi_injector_test
